//--- uart_flow_cfg.svh
// offsets, field positions, masks and reset values of the flow block
`ifndef UART_FLOW_CFG_SVH
`define UART_FLOW_CFG_SVH
// register offsets (byte addresses on the local port)
`define OFS_IER 4'h1
`define OFS_FCR_ISR 4'h2
`define OFS_MCR 4'h4
`define OFS_MSR 4'h6
`define OFS_SPR 4'h7
`define OFS_FEATURE_CONTROL 4'h8
`define OFS_EFR 4'h9
`define OFS_PAUSE2 4'ha
// field positions
`define EFR_AUTO_CTS 7
`define EFR_AUTO_RTS 6
`define EFR_SPECIAL 5
`define EFR_ENHANCED 4
`define MCR_LOOP 4
`define MCR_PAIR_SEL 2
`define FEATURE_CONTROL_RS485 5
`define FEATURE_CONTROL_IR_POL 4
`define LDE_TX_DIS 3
`define LDE_RX_DIS 2
`define LDE_NINE_BIT 0
`define IER_MODEM 3
`define IER_TX 1
`define ISR_SPECIAL 4
// enhanced bits that only change while the enhanced enable is set
`define ENH_MASK_IER 8'he0
`define ENH_MASK_FCR 8'h30
`define ENH_MASK_MCR 8'hec
`define ENH_MASK_LDE 8'hfc
// reserved bit of the write side of the modem status address
`define LDE_RSVD_MASK 8'h02
// reset values and the second-pair compare select code
`define RST_BYTE 8'h00
`define RST_SCRATCH 8'hff
`define RX_PAIR_SECOND 2'b01
`endif

//--- uart_flow_pkg.sv
// types shared by the flow and line control block
`default_nettype none
package uart_flow_pkg;
	// rs-485 direction sequencer, gray along rx -> tx -> turn -> tx; turn -> rx flips both bits
	typedef enum logic [1:0] {
		DIR_RX = 2'b00,
		DIR_TX = 2'b01,
		DIR_TURN = 2'b11
	} dir_state_type;
endpackage : uart_flow_pkg
`default_nettype wire

//--- uart_flow_line_ctrl.sv
// modem status, hardware flow control and rs-485 direction for one channel
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_cfg.svh"

module uart_flow_line_ctrl (
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// modem pins
	input wire logic cts_n_in,
	input wire logic dsr_n_in,
	input wire logic cd_n_in,
	input wire logic ri_n_in,
	output logic rts_n_out,
	output logic dtr_n_out,
	// serial receive line
	input wire logic rx_in,
	output logic rx_ir_data_out,
	// transmitter core
	input wire logic bit_tick_in,
	input wire logic tx_busy_in,
	input wire logic tx_char_done_in,
	input wire logic tx_fifo_empty_in,
	input wire logic tx_thr_empty_in,
	output logic tx_allow_out,
	// receiver core and fifo
	input wire logic rx_start_in,
	input wire logic rx_char_done_in,
	input wire logic [7:0] rx_char_in,
	input wire logic rx_trigger_in,
	input wire logic rx_above_upper_in,
	input wire logic rx_below_lower_in,
	output logic rx_allow_out,
	output logic rx_store_out,
	// modes and interrupt sources
	output logic [7:0] int_enable_out,
	output logic [7:0] fifo_control_out,
	output logic nine_bit_out,
	output logic loopback_out,
	output logic tx_int_out,
	output logic modem_int_out,
	output logic rx_trigger_int_out,
	output logic special_int_out,
	output logic pause_int_out,
	output uart_flow_pkg::dir_state_type dir_state_out
);
	import uart_flow_pkg::*;

	// -----------------------------------------------------------------
	// register file
	// -----------------------------------------------------------------
	logic [7:0] ier_q, fcr_q, mcr_q, lde_q, spr_q, feature_control_q, efr_q, pause2_q;
	logic wr_ier, wr_fcr, wr_mcr, wr_lde, wr_spr, wr_feature_control, wr_efr, wr_p2;
	logic enh_ok;

	// keep locked bits, take the others from the write data
	function automatic logic [7:0] merge_type_bits(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask, input logic en);
		merge_type_bits = en ? new_v : ((old_v & mask) | (new_v & ~mask));
	endfunction : merge_type_bits

	assign enh_ok = efr_q[`EFR_ENHANCED];
	// address decode for writes
	always_comb begin
		wr_ier = 1'b0;
		wr_fcr = 1'b0;
		wr_mcr = 1'b0;
		wr_lde = 1'b0;
		wr_spr = 1'b0;
		wr_feature_control = 1'b0;
		wr_efr = 1'b0;
		wr_p2 = 1'b0;
		if (reg_addr_in == `OFS_IER) begin
			wr_ier = reg_wr_in;
		end else if (reg_addr_in == `OFS_FCR_ISR) begin
			wr_fcr = reg_wr_in;
		end else if (reg_addr_in == `OFS_MCR) begin
			wr_mcr = reg_wr_in;
		end else if (reg_addr_in == `OFS_MSR) begin
			wr_lde = reg_wr_in;
		end else if (reg_addr_in == `OFS_SPR) begin
			wr_spr = reg_wr_in;
		end else if (reg_addr_in == `OFS_FEATURE_CONTROL) begin
			wr_feature_control = reg_wr_in;
		end else if (reg_addr_in == `OFS_EFR) begin
			wr_efr = reg_wr_in;
		end else if (reg_addr_in == `OFS_PAUSE2) begin
			wr_p2 = reg_wr_in;
		end
	end

	// enhanced bits locked while the enable is clear; legacy code
	// writing old values cannot disturb them
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ier_q <= `RST_BYTE;
			fcr_q <= `RST_BYTE;
			mcr_q <= `RST_BYTE;
			lde_q <= `RST_BYTE;
		end else begin
			if (wr_ier)
				ier_q <= merge_type_bits(ier_q, reg_wdata_in,
					`ENH_MASK_IER, enh_ok);
			if (wr_fcr)
				fcr_q <= merge_type_bits(fcr_q, reg_wdata_in,
					`ENH_MASK_FCR, enh_ok);
			if (wr_mcr)
				mcr_q <= merge_type_bits(mcr_q, reg_wdata_in,
					`ENH_MASK_MCR, enh_ok);
			if (wr_lde)
				lde_q <= merge_type_bits(lde_q, reg_wdata_in,
					`ENH_MASK_LDE, enh_ok) & ~`LDE_RSVD_MASK;
		end
	end

	// plain registers
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spr_q <= `RST_SCRATCH;
			feature_control_q <= `RST_BYTE;
			efr_q <= `RST_BYTE;
			pause2_q <= `RST_BYTE;
		end else begin
			if (wr_spr)
				spr_q <= reg_wdata_in;
			if (wr_feature_control)
				feature_control_q <= reg_wdata_in;
			if (wr_efr)
				efr_q <= reg_wdata_in;
			if (wr_p2)
				pause2_q <= reg_wdata_in;
		end
	end

	// -----------------------------------------------------------------
	// modem status view and change flags
	// -----------------------------------------------------------------
	logic [3:0] stat_now, stat_prev_q, delta_q, delta_set;
	logic stat_valid_q, msr_rd, loop;

	assign loop = mcr_q[`MCR_LOOP];
	// order: cd, ri, dsr, cts
	assign stat_now = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]}
		: ~{cd_n_in, ri_n_in, dsr_n_in, cts_n_in};
	assign msr_rd = reg_rd_in && (reg_addr_in == `OFS_MSR);
	// any edge for cd, dsr, cts; ri only when the input rises
	assign delta_set = {stat_now[3] ^ stat_prev_q[3],
		stat_prev_q[2] & ~stat_now[2],
		stat_now[1] ^ stat_prev_q[1],
		stat_now[0] ^ stat_prev_q[0]} & {4{stat_valid_q}};

	// prev view is caught only after reset release, so the first
	// cycle cannot fake a change
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stat_prev_q <= 4'h0;
			stat_valid_q <= 1'b0;
		end else begin
			stat_prev_q <= stat_now;
			stat_valid_q <= 1'b1;
		end
	end

	// a change that lands on the read is kept
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			delta_q <= 4'h0;
		else if (msr_rd)
			delta_q <= delta_set;
		else
			delta_q <= delta_q | delta_set;
	end

	// -----------------------------------------------------------------
	// special character detect
	// -----------------------------------------------------------------
	logic spec_match, spec_drop, spec_flag_q, isr_rd;

	assign spec_match = rx_char_done_in && efr_q[`EFR_SPECIAL]
		&& (rx_char_in == pause2_q);
	assign spec_drop = spec_match
		&& (efr_q[1:0] == `RX_PAIR_SECOND);
	assign isr_rd = reg_rd_in && (reg_addr_in == `OFS_FCR_ISR);

	// source bit held until the source register is read
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			spec_flag_q <= 1'b0;
		else if (spec_match)
			spec_flag_q <= 1'b1;
		else if (isr_rd)
			spec_flag_q <= 1'b0;
	end

	// fifo store strobe and pause / special pulses
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_store_out <= 1'b0;
			special_int_out <= 1'b0;
			pause_int_out <= 1'b0;
		end else begin
			rx_store_out <= rx_char_done_in && !spec_drop;
			special_int_out <= spec_match;
			pause_int_out <= spec_drop;
		end
	end

	// -----------------------------------------------------------------
	// read data, valid only in the cycle after the strobe
	// -----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= `RST_BYTE;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= `RST_BYTE;
		end else if (reg_addr_in == `OFS_IER) begin
			reg_rdata_out <= ier_q;
		end else if (reg_addr_in == `OFS_FCR_ISR) begin
			reg_rdata_out <= {3'h0, spec_flag_q, 4'h0};
		end else if (reg_addr_in == `OFS_MCR) begin
			reg_rdata_out <= mcr_q;
		end else if (reg_addr_in == `OFS_MSR) begin
			reg_rdata_out <= {stat_now, delta_q};
		end else if (reg_addr_in == `OFS_SPR) begin
			reg_rdata_out <= spr_q;
		end else if (reg_addr_in == `OFS_FEATURE_CONTROL) begin
			reg_rdata_out <= feature_control_q;
		end else if (reg_addr_in == `OFS_EFR) begin
			reg_rdata_out <= efr_q;
		end else begin
			reg_rdata_out <= `RST_BYTE;
		end
	end

	// -----------------------------------------------------------------
	// rs-485 direction sequencer
	// -----------------------------------------------------------------
	dir_state_type dir_q;
	logic [3:0] turn_cnt_q;
	logic rs485;

	assign rs485 = feature_control_q[`FEATURE_CONTROL_RS485];
	// direction turns only once both fifo and shift register drained
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dir_q <= DIR_RX;
			turn_cnt_q <= 4'h0;
		end else begin
			case (dir_q)
				DIR_RX: begin
					if (rs485 && !tx_fifo_empty_in)
						dir_q <= DIR_TX;
				end
				DIR_TX: begin
					if (tx_char_done_in && tx_fifo_empty_in) begin
						dir_q <= DIR_TURN;
						turn_cnt_q <= lde_q[7:4];
					end
				end
				DIR_TURN: begin
					if (!tx_fifo_empty_in)
						dir_q <= DIR_TX;
					else if (turn_cnt_q == 4'h0)
						dir_q <= DIR_RX;
					else if (bit_tick_in)
						turn_cnt_q <= turn_cnt_q - 4'h1;
				end
				default: dir_q <= DIR_RX;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// transmit gating and modem outputs
	// -----------------------------------------------------------------
	logic tx_gate, rx_hold_q, hold_rts, hold_dtr;

	// the core only asks this before loading the next character, so
	// a character already shifting always completes
	assign tx_gate = efr_q[`EFR_AUTO_CTS] && (mcr_q[`MCR_PAIR_SEL]
		? dsr_n_in : cts_n_in);

	// hysteresis between the upper and lower receive triggers
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			rx_hold_q <= 1'b0;
		else if (!efr_q[`EFR_AUTO_RTS])
			rx_hold_q <= 1'b0;
		else if (rx_above_upper_in)
			rx_hold_q <= 1'b1;
		else if (rx_below_lower_in)
			rx_hold_q <= 1'b0;
	end

	assign hold_rts = rx_hold_q && !mcr_q[`MCR_PAIR_SEL];
	assign hold_dtr = rx_hold_q && mcr_q[`MCR_PAIR_SEL];

	// pins are general outputs unless flow control overrides them
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rts_n_out <= 1'b1;
			dtr_n_out <= 1'b1;
			tx_allow_out <= 1'b0;
		end else begin
			rts_n_out <= rs485 ? (dir_q != DIR_RX)
				: (!mcr_q[1] || hold_rts);
			dtr_n_out <= !mcr_q[0] || hold_dtr;
			tx_allow_out <= !lde_q[`LDE_TX_DIS] && !tx_gate
				&& (!rs485 || dir_q == DIR_TX);
		end
	end

	// -----------------------------------------------------------------
	// receiver disable: one more character when idle at the set
	// -----------------------------------------------------------------
	logic rx_busy_q, rx_dis_prev_q, rx_credit_q, rx_dis;

	assign rx_dis = lde_q[`LDE_RX_DIS];
	// busy window from start detect to character done
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			rx_busy_q <= 1'b0;
		else if (rx_start_in)
			rx_busy_q <= 1'b1;
		else if (rx_char_done_in)
			rx_busy_q <= 1'b0;
	end

	// credit for the one extra character; spent at its start bit
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_dis_prev_q <= 1'b0;
			rx_credit_q <= 1'b0;
		end else begin
			rx_dis_prev_q <= rx_dis;
			if (rx_dis && !rx_dis_prev_q)
				rx_credit_q <= !rx_busy_q;
			else if (rx_start_in || !rx_dis)
				rx_credit_q <= 1'b0;
		end
	end

	// fifo reads never pass through here, so it stays readable
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_allow_out <= 1'b1;
			rx_ir_data_out <= 1'b0;
		end else begin
			rx_allow_out <= !rx_dis || (rx_credit_q && !rx_start_in)
				|| (rx_dis && !rx_dis_prev_q && !rx_busy_q);
			rx_ir_data_out <= rx_in ^ feature_control_q[`FEATURE_CONTROL_IR_POL];
		end
	end

	// -----------------------------------------------------------------
	// interrupt sources and mode outputs
	// -----------------------------------------------------------------
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_int_out <= 1'b0;
			modem_int_out <= 1'b0;
			rx_trigger_int_out <= 1'b0;
			nine_bit_out <= 1'b0;
			loopback_out <= 1'b0;
			int_enable_out <= `RST_BYTE;
			fifo_control_out <= `RST_BYTE;
			dir_state_out <= DIR_RX;
		end else begin
			tx_int_out <= ier_q[`IER_TX] && (rs485
				? (tx_thr_empty_in && !tx_busy_in) : tx_thr_empty_in);
			modem_int_out <= ier_q[`IER_MODEM] && (|delta_q);
			rx_trigger_int_out <= efr_q[`EFR_AUTO_RTS] && rx_trigger_in;
			nine_bit_out <= lde_q[`LDE_NINE_BIT];
			loopback_out <= loop;
			int_enable_out <= ier_q;
			fifo_control_out <= fcr_q;
			dir_state_out <= dir_q;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_cts_gate_halt: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (efr_q[7] && !mcr_q[2] && cts_n_in)
		|=> !tx_allow_out) else $error("sending allowed with CTS high");
	a_cts_status_view: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (msr_rd && !loop)
		|=> reg_rdata_out[4] == !$past(cts_n_in))
		else $error("status bit 4 not inverted CTS");
	a_delta_cts_set: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (stat_valid_q && stat_now[0] != stat_prev_q[0])
		|=> delta_q[0]) else $error("CTS change flag missed");
	a_ri_fall_ignored: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		(!delta_q[2] && !stat_prev_q[2] && stat_now[2]) |=> !delta_q[2])
		else $error("ring flag set on wrong edge");
	a_turn_count_down: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (dir_q == DIR_TURN && tx_fifo_empty_in
		&& bit_tick_in && turn_cnt_q != 4'h0)
		|=> turn_cnt_q == $past(turn_cnt_q) - 4'h1)
		else $error("turnaround count not one per bit");
	a_delay_bits_locked: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (wr_lde && !enh_ok)
		|=> lde_q[7:2] == $past(lde_q[7:2]))
		else $error("locked delay bits changed");
	a_tx_disable_halt: assert property (@(posedge clock_in)
		disable iff (!resetn_in) lde_q[3] |=> !tx_allow_out)
		else $error("sending allowed while disabled");
	a_rx_disable_stop: assert property (@(posedge clock_in)
		disable iff (!resetn_in) (rx_dis && rx_dis_prev_q && !rx_credit_q)
		|=> !rx_allow_out) else $error("receiver not stopped");
	a_special_drop: assert property (@(posedge clock_in)
		disable iff (!resetn_in) spec_drop
		|=> (!rx_store_out && pause_int_out && special_int_out))
		else $error("second pause char not dropped");
endmodule : uart_flow_line_ctrl
`default_nettype wire

//--- uart_line_partner.sv
// modem and rs-485 transceiver model on the serial side of the block
`timescale 1ns/1ps
`default_nettype none
module uart_line_partner (
	// line levels asked for by the bench: rx, ri, cd, dsr, cts
	input wire logic [4:0] want_in,
	// direction pin from the device
	input wire logic rts_n_in,
	// modem pins toward the device, active low, and the serial receive line
	output logic cts_n_out,
	output logic dsr_n_out,
	output logic cd_n_out,
	output logic ri_n_out,
	output logic rx_out,
	// transceiver driver enable as seen on the cable
	output logic line_drive_out
);
	// pins follow the request at once, so they are valid from time zero
	assign cts_n_out = want_in[0]; // high pauses the device, low resumes
	assign dsr_n_out = want_in[1];
	assign cd_n_out = want_in[2];
	assign ri_n_out = want_in[3];
	assign rx_out = want_in[4]; // kept high while no frame is sent
	// driver enabled while the device holds the direction pin high
	assign line_drive_out = rts_n_in;
endmodule : uart_line_partner
`default_nettype wire

//--- test_uart_flow_line_ctrl.sv
// self-checking bench for the flow and line control block
`timescale 1ns/1ps
`default_nettype none
module test_uart_flow_line_ctrl;
	import uart_flow_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [3:0] a_ien = 4'h1, a_src = 4'h2, a_mctl = 4'h4;
	localparam logic [3:0] a_stat = 4'h6, a_scr = 4'h7, a_fctl = 4'h8;
	localparam logic [3:0] a_enh = 4'h9, a_pause = 4'ha, a_none = 4'hf;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, rd_val, rchar = 8'h00, ien, fctl;
	logic wr = 1'b0, rd = 1'b0, tick = 1'b0, busy = 1'b0, done = 1'b0;
	logic fempty = 1'b1, thr_empty = 1'b1, rstart = 1'b0, rdone = 1'b0;
	logic rtrig = 1'b0, rup = 1'b0, rlow = 1'b0;
	logic [4:0] want = 5'h1f;
	logic cts_n, dsr_n, cd_n, ri_n, rx, rts_n, dtr_n, ir, drive, allow;
	logic rallow, store, nine, loop, txint, mint, tint, spec, pause;
	dir_state_type dir;
	int fails = 0;
	int checks_done = 0;
	logic [4:0] pins [0:5] = '{5'h1e, 5'h16, 5'h1e, 5'h18, 5'h1e, 5'h1f};
	logic [7:0] stat_exp [0:5] = '{8'h11, 8'h50, 8'h14, 8'hba, 8'h1a, 8'h01};
	logic [7:0] dval [0:2] = '{8'hf0, 8'h30, 8'hf0};
	logic [7:0] enh [0:2] = '{8'h00, 8'h10, 8'h10};
	int dexp [0:2] = '{0, 3, 15};

	// 200 MHz clock
	always #2.5 clock_in = ~clock_in;

	uart_flow_line_ctrl dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .cts_n_in(cts_n),
		.dsr_n_in(dsr_n), .cd_n_in(cd_n), .ri_n_in(ri_n), .rts_n_out(rts_n),
		.dtr_n_out(dtr_n), .rx_in(rx), .rx_ir_data_out(ir),
		.bit_tick_in(tick), .tx_busy_in(busy), .tx_char_done_in(done),
		.tx_fifo_empty_in(fempty), .tx_thr_empty_in(thr_empty),
		.tx_allow_out(allow), .rx_start_in(rstart), .rx_char_done_in(rdone),
		.rx_char_in(rchar), .rx_trigger_in(rtrig),
		.rx_above_upper_in(rup), .rx_below_lower_in(rlow),
		.rx_allow_out(rallow), .rx_store_out(store), .int_enable_out(ien),
		.fifo_control_out(fctl), .nine_bit_out(nine), .loopback_out(loop),
		.tx_int_out(txint), .modem_int_out(mint),
		.rx_trigger_int_out(tint), .special_int_out(spec),
		.pause_int_out(pause), .dir_state_out(dir));

	uart_line_partner p_u (.want_in(want), .rts_n_in(rts_n),
		.cts_n_out(cts_n), .dsr_n_out(dsr_n), .cd_n_out(cd_n),
		.ri_n_out(ri_n), .rx_out(rx), .line_drive_out(drive));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask : wr_reg
	// data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clock_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd <= 1'b0;
		#1 rd_val = rdata;
	endtask : rd_reg
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : wait_cyc
	task automatic pulse_tick;
		@(posedge clock_in);
		tick <= 1'b1;
		@(posedge clock_in);
		tick <= 1'b0;
	endtask : pulse_tick
	task automatic gate_case(input logic [7:0] m, input logic [4:0] p,
		input logic [7:0] l, input logic e);
		wr_reg(a_mctl, m);
		wr_reg(a_stat, l);
		@(posedge clock_in);
		want <= p;
		wait_cyc(3);
		check({7'h0, allow}, {7'h0, e});
	endtask : gate_case
	// one rs-485 frame end, then the turnaround delay in bit ticks
	task automatic run485(input int d);
		@(posedge clock_in);
		fempty <= 1'b0;
		wait_cyc(3);
		check({6'h0, dir}, {6'h0, DIR_TX});
		check({7'h0, drive}, 8'h01);
		@(posedge clock_in);
		fempty <= 1'b1;
		done <= 1'b1;
		@(posedge clock_in);
		done <= 1'b0;
		if (d > 0) begin
			repeat (d - 1) pulse_tick();
			wait_cyc(2);
			check({6'h0, dir}, {6'h0, DIR_TURN});
			pulse_tick();
		end
		wait_cyc(3);
		check({6'h0, dir}, {6'h0, DIR_RX});
		check({7'h0, drive}, 8'h00);
	endtask : run485
	task automatic rx_char(input logic [7:0] c, input logic [2:0] e);
		@(posedge clock_in);
		rdone <= 1'b1;
		rchar <= c;
		@(posedge clock_in);
		rdone <= 1'b0;
		#1 check({5'h0, store, spec, pause}, {5'h0, e});
	endtask : rx_char
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// a hang is cut short well after the sequence should end
	initial begin
		#60000;
		fails++;
		end_of_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd_reg(a_scr);
		check(rd_val, 8'hff);
		check({6'h0, rts_n, dtr_n}, 8'h03);
		wr_reg(a_scr, 8'h5a);
		wr_reg(a_none, 8'h77);
		rd_reg(a_scr);
		check(rd_val, 8'h5a);
		rd_reg(a_none);
		check(rd_val, 8'h00);
		$display("test reset and scratch done");
		// enhanced bits hold while the enable is clear
		wr_reg(a_ien, 8'he8);
		wait_cyc(1);
		check(ien, 8'h08);
		wr_reg(a_enh, 8'h10);
		wr_reg(a_ien, 8'he8);
		wr_reg(a_src, 8'h30);
		wr_reg(a_enh, 8'h00);
		wr_reg(a_ien, 8'h08);
		wr_reg(a_src, 8'h00);
		wait_cyc(1);
		check(ien, 8'he8);
		check(fctl, 8'h30);
		$display("test enhanced latch done");
		// modem pin changes, flags and clear on read
		rd_reg(a_stat);
		for (int i = 0; i < 6; i++) begin
			@(posedge clock_in);
			want <= pins[i];
			wait_cyc(3);
			check({7'h0, mint}, {7'h0, |stat_exp[i][3:0]});
			rd_reg(a_stat);
			check(rd_val, stat_exp[i]);
		end
		rd_reg(a_stat);
		check(rd_val, 8'h00);
		wr_reg(a_mctl, 8'h12);
		wait_cyc(2);
		check({7'h0, loop}, 8'h01);
		rd_reg(a_stat);
		check(rd_val & 8'hf0, 8'h10);
		wr_reg(a_mctl, 8'h00);
		$display("test modem status done");
		// transmit gating on the selected pin and transmit disable
		wr_reg(a_enh, 8'h90);
		gate_case(8'h00, 5'h1f, 8'h00, 1'b0);
		gate_case(8'h00, 5'h1e, 8'h00, 1'b1);
		gate_case(8'h04, 5'h1e, 8'h00, 1'b0);
		gate_case(8'h04, 5'h1d, 8'h00, 1'b1);
		gate_case(8'h04, 5'h1d, 8'h08, 1'b0);
		gate_case(8'h04, 5'h1d, 8'h00, 1'b1);
		wr_reg(a_mctl, 8'h00);
		$display("test transmit gating done");
		// direction control with delay 0, 3 and 15
		@(posedge clock_in);
		busy <= 1'b1;
		wr_reg(a_enh, 8'h00);
		wr_reg(a_ien, 8'h02);
		wait_cyc(2);
		check({7'h0, txint}, 8'h01);
		wr_reg(a_fctl, 8'h20);
		wait_cyc(2);
		check({7'h0, txint}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr_reg(a_enh, enh[i]);
			wr_reg(a_stat, dval[i]);
			run485(dexp[i]);
		end
		@(posedge clock_in);
		busy <= 1'b0;
		wr_reg(a_fctl, 8'h00);
		$display("test direction control done");
		// receiver disable while idle, then while busy
		wr_reg(a_stat, 8'h05);
		wait_cyc(2);
		check({6'h0, nine, rallow}, 8'h03);
		@(posedge clock_in);
		rstart <= 1'b1;
		@(posedge clock_in);
		rstart <= 1'b0;
		wait_cyc(2);
		check({7'h0, rallow}, 8'h00);
		wr_reg(a_stat, 8'h01);
		wait_cyc(2);
		check({7'h0, rallow}, 8'h01);
		@(posedge clock_in);
		rstart <= 1'b1;
		@(posedge clock_in);
		rstart <= 1'b0;
		wr_reg(a_stat, 8'h05);
		wait_cyc(2);
		check({7'h0, rallow}, 8'h00);
		rx_char(8'h20, 3'b100);
		wr_reg(a_stat, 8'h00);
		$display("test receiver disable done");
		// special character detect, plain and with second pair compare
		wr_reg(a_pause, 8'h13);
		wr_reg(a_enh, 8'h30);
		rx_char(8'h13, 3'b110);
		rd_reg(a_src);
		check(rd_val & 8'h10, 8'h10);
		rx_char(8'h14, 3'b100);
		wr_reg(a_enh, 8'h31);
		rx_char(8'h13, 3'b011);
		wr_reg(a_enh, 8'h30); // select field cleared first
		$display("test special character done");
		// receive flow control on the request pin
		wr_reg(a_mctl, 8'h02); // pin asserted before auto mode
		wait_cyc(2);
		check({7'h0, rts_n}, 8'h00);
		wr_reg(a_enh, 8'h50);
		@(posedge clock_in);
		rup <= 1'b1;
		rtrig <= 1'b1;
		wait_cyc(3);
		check({6'h0, rts_n, tint}, 8'h03);
		@(posedge clock_in);
		rup <= 1'b0;
		rlow <= 1'b1;
		rtrig <= 1'b0;
		wait_cyc(3);
		check({7'h0, rts_n}, 8'h00);
		@(posedge clock_in);
		rlow <= 1'b0;
		wr_reg(a_mctl, 8'h01);
		wait_cyc(2);
		check({7'h0, dtr_n}, 8'h00);
		$display("test receive flow control done");
		// infrared receive polarity
		wr_reg(a_fctl, 8'h10);
		wait_cyc(2);
		check({7'h0, ir}, 8'h00);
		wr_reg(a_fctl, 8'h00);
		wait_cyc(2);
		check({7'h0, ir}, 8'h01);
		$display("test infrared polarity done");
		// second reset in mid-run restores defaults
		@(posedge clock_in);
		resetn_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd_reg(a_scr);
		check(rd_val, 8'hff);
		check(ien, 8'h00);
		$display("test second reset done");
		end_of_test();
	end
endmodule : test_uart_flow_line_ctrl
`default_nettype wire
